// *** sbrap_pkg_sync.sv ***
// shared constants and types of the request address phase, plus the pin synchroniser
// assumes one 100 MHz system clock; every pin input is foreign to it
package sbrap_pkg;
    localparam int ADDR_W = 33; // address lines 35..3, the three low bits are not on the bus
    localparam int ADDR_LSB = 3; // lowest bus-carried address bit
    localparam int BIT20_IDX = 20 - ADDR_LSB; // position of line twenty in the word
    localparam int GRP0_MSB = 16 - ADDR_LSB; // strobe 0 latches lines 16..3
    localparam int PAR0_LSB = 24 - ADDR_LSB; // parity 1 covers lines 35..24
    localparam int SYS_CLK_MHZ = 100; // system clock rate
    localparam int STB_SETUP_NS = 20; // data stands this long before a strobe edge
    localparam int STB_SETUP_CYC = (STB_SETUP_NS * SYS_CLK_MHZ + 999) / 1000; // rounded up
    localparam int SYNC_STAGES = 2; // flip-flops in every synchroniser
    localparam logic [1:0] STB_EDGES = 2'h2; // one edge per subphase
    localparam logic [ADDR_W-1:0] ADDR_RST = {ADDR_W{1'b0}}; // captured words after reset

    // transmit sequence, gray along the usual path
    typedef enum logic [1:0] {
        SBRAP_TX_IDLE = 2'h0,
        SBRAP_TX_SUB1 = 2'h1,
        SBRAP_TX_SUB2 = 2'h3,
        SBRAP_TX_DONE = 2'h2
    } sbrap_tx_t;

    // one received request as handed to the core
    typedef struct packed {
        logic [ADDR_W-1:0] addr; // logical address, subphase one
        logic [ADDR_W-1:0] kind; // logical transaction type, subphase two
        logic par_err; // parity mismatch in either subphase
    } sbrap_rx_t;

    // one request the core hands to the bus
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] kind;
    } sbrap_req_t;

    // parity level: high when an even number of the covered pins are low
    function automatic logic sbrap_par(input logic [ADDR_W-1:0] pins, input logic upper);
        logic [ADDR_W-1:0] lows;
        logic odd;
        lows = ~pins;
        odd = 1'b0;
        for (int i = 0; i < ADDR_W; i++) begin
            if ((i >= PAR0_LSB) == upper) begin
                odd = odd ^ lows[i];
            end
        end
        return ~odd;
    endfunction
endpackage

`timescale 1ns/10ps
`default_nettype none

// plain double flip-flop synchroniser, one per bit
module sbrap_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // first stage, read only by the second
    logic [W-1:0] q_r;

    // two stages, nothing taps the first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule // sbrap_sync

`default_nettype wire

// *** sbrap_top.sv ***
// request address phase of the system bus: drive, receive, parity, reset strap, bit 20 mask
// assumes the bus clock and all bus pins are asynchronous; the pad ring resolves the wires
`timescale 1ns/10ps
`default_nettype none

module sbrap_top
    import sbrap_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic BUS_CLK, // bus clock, sampled here
    input wire logic BUS_RESET_N, // bus reset pin
    input wire logic BIT20_MASK_IN_N, // asynchronous mask pin
    input wire logic REAL_MODE, // core runs in real mode
    input wire logic REQ_VALID, // core has a request
    input wire sbrap_req_t REQ_WORD, // request address and type
    output logic REQ_READY,
    output logic [ADDR_W-1:0] LOOKUP_ADDR, // masked address for cache lookup
    input wire logic [ADDR_W-1:0] ADDR_LINES_N_IN,
    output logic [ADDR_W-1:0] ADDR_LINES_N_OUT,
    output logic ADDR_LINES_OE,
    input wire logic [1:0] ADDR_SRC_STROBES_N_IN,
    output logic [1:0] ADDR_SRC_STROBES_N_OUT,
    output logic ADDR_SRC_STROBES_OE,
    input wire logic [1:0] ADDR_PARITY_PAIR_N_IN,
    output logic [1:0] ADDR_PARITY_PAIR_N_OUT,
    output logic ADDR_PARITY_PAIR_OE,
    input wire logic ADDR_VALID_STROBE_N_IN,
    output logic ADDR_VALID_STROBE_N_OUT,
    output logic ADDR_VALID_STROBE_OE,
    output logic RX_VALID, // one-cycle pulse per received request
    output sbrap_rx_t RX_WORD,
    output logic [ADDR_W-1:0] CFG_WORD // power-on configuration strap
);
    localparam int SW = ADDR_W + 8; // synchronised pin count
    // idle level of every pin; the synchroniser clears to zero, so pins pass xored with
    // this and read idle after reset: no false strobe, bus reset or clock edge follows
    localparam logic [SW-1:0] PIN_IDLE = {{ADDR_W{1'b1}}, 2'h3, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1};
    localparam logic [7:0] SETUP_CNT = 8'(STB_SETUP_CYC); // strobe setup count

    initial begin
        if (STB_SETUP_CYC < 1 || STB_SETUP_CYC > 255) begin
            $error("strobe setup count out of range");
        end
    end

    // every pin passes the synchroniser before any logic reads it
    logic [SW-1:0] pins_s;
    logic [ADDR_W-1:0] lines_s;
    logic [1:0] stb_s, par_s;
    logic ads_s, bclk_s, brst_s, mask_s;

    sbrap_sync #(.W(SW)) u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .d({ADDR_LINES_N_IN, ADDR_SRC_STROBES_N_IN, ADDR_PARITY_PAIR_N_IN,
            ADDR_VALID_STROBE_N_IN, BUS_CLK, BUS_RESET_N, BIT20_MASK_IN_N} ^ PIN_IDLE),
        .q(pins_s)
    );
    assign {lines_s, stb_s, par_s, ads_s, bclk_s, brst_s, mask_s} = pins_s ^ PIN_IDLE;

    // edge history of synchronised bus clock, reset and strobes
    logic bclk_q_r, brst_q_r;
    logic [1:0] stb_q_r;
    logic bus_rise, rst_release;
    logic [1:0] stb_edge;
    assign bus_rise = bclk_s & ~bclk_q_r;
    assign rst_release = brst_s & ~brst_q_r;
    assign stb_edge = stb_s ^ stb_q_r; // both edges are active

    // transmit state
    sbrap_tx_t tx_r, tx_nxt;
    logic [7:0] dly_r, dly_nxt;
    sbrap_req_t hold_r, hold_nxt;
    logic pend_r, pend_nxt, rdy_r, rdy_nxt;
    logic [ADDR_W-1:0] look_r, look_nxt, lo_r, lo_nxt;
    logic loe_r, loe_nxt, soe_r, soe_nxt, poe_r, poe_nxt, aoe_r, aoe_nxt, ao_r, ao_nxt;
    logic [1:0] so_r, so_nxt, po_r, po_nxt;
    logic [ADDR_W-1:0] masked; // request address after the bit 20 mask

    // receive state
    logic arm_r, arm_nxt, rxv_r, rxv_nxt;
    logic [1:0] cnt_r [2];
    logic [1:0] cnt_nxt [2];
    sbrap_rx_t rx_r, rx_nxt;
    logic [ADDR_W-1:0] cfg_r, cfg_nxt;

    // line twenty forced low while the mask pin is low, only in real mode
    always_comb begin
        masked = REQ_WORD.addr;
        if (mask_s == 1'b0 && REAL_MODE) begin
            masked[BIT20_IDX] = 1'b0;
        end
    end

    // transmit: take a request, then two subphases on bus clock edges
    always_comb begin
        tx_nxt = tx_r;
        dly_nxt = dly_r;
        hold_nxt = hold_r;
        pend_nxt = pend_r;
        rdy_nxt = 1'b0;
        look_nxt = look_r;
        lo_nxt = lo_r;
        loe_nxt = loe_r;
        so_nxt = so_r;
        soe_nxt = soe_r;
        po_nxt = po_r;
        poe_nxt = poe_r;
        ao_nxt = ao_r;
        aoe_nxt = aoe_r;
        // accept one request while nothing is pending
        if (!pend_r && !rdy_r && REQ_VALID) begin
            rdy_nxt = 1'b1;
            pend_nxt = 1'b1;
            hold_nxt.addr = masked;
            hold_nxt.kind = REQ_WORD.kind;
            look_nxt = masked; // cache lookup sees the same masked address
        end
        if (dly_r != 8'h00) begin
            dly_nxt = dly_r - 8'h01;
        end
        case (tx_r)
            SBRAP_TX_IDLE: begin
                // no driving while the bus sits in reset or another agent starts
                if (pend_r && bus_rise && brst_s && ads_s && !arm_r) begin
                    tx_nxt = SBRAP_TX_SUB1;
                    lo_nxt = ~hold_r.addr;
                    loe_nxt = 1'b1;
                    po_nxt = {sbrap_par(~hold_r.addr, 1'b1),
                              sbrap_par(~hold_r.addr, 1'b0)};
                    poe_nxt = 1'b1;
                    ao_nxt = 1'b0;
                    aoe_nxt = 1'b1;
                    so_nxt = 2'h3;
                    soe_nxt = 1'b1;
                    dly_nxt = SETUP_CNT;
                end
            end
            SBRAP_TX_SUB1: begin
                if (dly_r == 8'h01) begin
                    so_nxt = 2'h0;
                end
                if (bus_rise) begin
                    tx_nxt = SBRAP_TX_SUB2;
                    lo_nxt = ~hold_r.kind;
                    po_nxt = {sbrap_par(~hold_r.kind, 1'b1),
                              sbrap_par(~hold_r.kind, 1'b0)};
                    ao_nxt = 1'b1; // valid strobe lasts one bus clock
                    dly_nxt = SETUP_CNT;
                end
            end
            SBRAP_TX_SUB2: begin
                if (dly_r == 8'h01) begin
                    so_nxt = 2'h3;
                end
                if (bus_rise) begin
                    tx_nxt = SBRAP_TX_DONE;
                end
            end
            SBRAP_TX_DONE: begin
                // release every pin, pull-ups restore the idle level
                tx_nxt = SBRAP_TX_IDLE;
                loe_nxt = 1'b0;
                soe_nxt = 1'b0;
                poe_nxt = 1'b0;
                aoe_nxt = 1'b0;
                pend_nxt = 1'b0;
            end
            default: tx_nxt = SBRAP_TX_IDLE;
        endcase
    end

    // receive: arm on valid strobe, latch halves on their own strobe edges
    always_comb begin
        arm_nxt = arm_r;
        rxv_nxt = 1'b0;
        rx_nxt = rx_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        if (rst_release) begin
            cfg_nxt = ~lines_s;
        end
        // own transfers are not received; a new request starts all checks
        if (!arm_r && tx_r == SBRAP_TX_IDLE && bus_rise && !ads_s && brst_s) begin
            arm_nxt = 1'b1;
            cnt_nxt[0] = 2'h0;
            cnt_nxt[1] = 2'h0;
            rx_nxt.par_err = 1'b0;
        end
        if (arm_r) begin
            for (int g = 0; g < 2; g++) begin
                if (stb_edge[g] && cnt_r[g] != STB_EDGES) begin
                    cnt_nxt[g] = cnt_r[g] + 2'h1;
                    for (int b = 0; b < ADDR_W; b++) begin
                        if ((b > GRP0_MSB) == (g == 1)) begin
                            if (cnt_r[g] == 2'h0) begin
                                rx_nxt.addr[b] = ~lines_s[b];
                            end else begin
                                rx_nxt.kind[b] = ~lines_s[b];
                            end
                        end
                    end
                end
            end
            // parity checked per subphase at the strobe 0 edge
            if (stb_edge[0] && cnt_r[0] != STB_EDGES) begin
                if (par_s != {sbrap_par(lines_s, 1'b1), sbrap_par(lines_s, 1'b0)}) begin
                    rx_nxt.par_err = 1'b1;
                end
            end
            // both strobes have delivered both words
            if (cnt_r[0] == STB_EDGES && cnt_r[1] == STB_EDGES) begin
                arm_nxt = 1'b0;
                rxv_nxt = 1'b1;
            end
        end
        if (!brst_s) begin
            arm_nxt = 1'b0; // bus reset aborts a half-received request
        end
    end

    // register every group of state
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bclk_q_r <= 1'b0;
            brst_q_r <= 1'b1; // idle level, so a core reset alone loads no strap
            stb_q_r <= 2'h3; // idle level of the strobes
            tx_r <= SBRAP_TX_IDLE;
            dly_r <= 8'h00;
            hold_r <= '0;
            pend_r <= 1'b0;
            rdy_r <= 1'b0;
            look_r <= ADDR_RST;
            lo_r <= {ADDR_W{1'b1}};
            loe_r <= 1'b0;
            so_r <= 2'h3;
            soe_r <= 1'b0;
            po_r <= 2'h3;
            poe_r <= 1'b0;
            ao_r <= 1'b1;
            aoe_r <= 1'b0;
            arm_r <= 1'b0;
            rxv_r <= 1'b0;
            cnt_r[0] <= 2'h0;
            cnt_r[1] <= 2'h0;
            rx_r <= '0;
            cfg_r <= ADDR_RST;
        end else begin
            bclk_q_r <= bclk_s;
            brst_q_r <= brst_s;
            stb_q_r <= stb_s;
            tx_r <= tx_nxt;
            dly_r <= dly_nxt;
            hold_r <= hold_nxt;
            pend_r <= pend_nxt;
            rdy_r <= rdy_nxt;
            look_r <= look_nxt;
            lo_r <= lo_nxt;
            loe_r <= loe_nxt;
            so_r <= so_nxt;
            soe_r <= soe_nxt;
            po_r <= po_nxt;
            poe_r <= poe_nxt;
            ao_r <= ao_nxt;
            aoe_r <= aoe_nxt;
            arm_r <= arm_nxt;
            rxv_r <= rxv_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // outputs straight from flip-flops
    assign REQ_READY = rdy_r;
    assign LOOKUP_ADDR = look_r;
    assign ADDR_LINES_N_OUT = lo_r;
    assign ADDR_LINES_OE = loe_r;
    assign ADDR_SRC_STROBES_N_OUT = so_r;
    assign ADDR_SRC_STROBES_OE = soe_r;
    assign ADDR_PARITY_PAIR_N_OUT = po_r;
    assign ADDR_PARITY_PAIR_OE = poe_r;
    assign ADDR_VALID_STROBE_N_OUT = ao_r;
    assign ADDR_VALID_STROBE_OE = aoe_r;
    assign RX_VALID = rxv_r;
    assign RX_WORD = rx_r;
    assign CFG_WORD = cfg_r;
endmodule // sbrap_top

`default_nettype wire

// *** sbrap_asserts.sv ***
// checker of the request address phase pins
// assumes the ports of sbrap_top only; bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module sbrap_asserts
    import sbrap_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic BIT20_MASK_IN_N,
    input wire logic REAL_MODE,
    input wire logic REQ_READY,
    input wire logic [ADDR_W-1:0] LOOKUP_ADDR,
    input wire logic [ADDR_W-1:0] ADDR_LINES_N_OUT,
    input wire logic ADDR_LINES_OE,
    input wire logic [1:0] ADDR_SRC_STROBES_N_OUT,
    input wire logic [1:0] ADDR_PARITY_PAIR_N_OUT,
    input wire logic ADDR_PARITY_PAIR_OE,
    input wire logic ADDR_VALID_STROBE_N_OUT,
    input wire logic ADDR_VALID_STROBE_OE,
    input wire logic RX_VALID
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // subphase one: strobes stand high two cycles, then fall
    sequence s_sub1;
        (ADDR_SRC_STROBES_N_OUT == 2'h3) [*2] ##1 ADDR_SRC_STROBES_N_OUT == 2'h0;
    endsequence
    // subphase two: strobes stand low two cycles, then rise
    sequence s_sub2;
        (ADDR_SRC_STROBES_N_OUT == 2'h0) [*2] ##1 ADDR_SRC_STROBES_N_OUT == 2'h3;
    endsequence
    chk_sub1_strobes: assert property ($rose(ADDR_LINES_OE) |-> s_sub1)
        else $error("strobes wrong in subphase one");
    chk_sub2_strobes: assert property (
        $rose(ADDR_VALID_STROBE_N_OUT) && ADDR_VALID_STROBE_OE |-> s_sub2)
        else $error("strobes wrong in subphase two");
    chk_valid_opens: assert property (
        $rose(ADDR_LINES_OE) |-> ADDR_VALID_STROBE_OE && !ADDR_VALID_STROBE_N_OUT)
        else $error("valid strobe not low at start");
    chk_bus_addr: assert property ($rose(ADDR_LINES_OE) |-> ADDR_LINES_N_OUT == ~LOOKUP_ADDR)
        else $error("bus address differs from lookup");
    chk_par_low: assert property (
        ADDR_PARITY_PAIR_OE |-> ADDR_PARITY_PAIR_N_OUT[0] == ~^(~ADDR_LINES_N_OUT[PAR0_LSB-1:0]))
        else $error("low parity pin wrong");
    chk_par_high: assert property (
        ADDR_PARITY_PAIR_OE |-> ADDR_PARITY_PAIR_N_OUT[1] == ~^(~ADDR_LINES_N_OUT[32:PAR0_LSB]))
        else $error("high parity pin wrong");
    chk_mask_lookup: assert property ($rose(REQ_READY) && REAL_MODE &&
        !BIT20_MASK_IN_N && !$past(BIT20_MASK_IN_N, 4) |-> !LOOKUP_ADDR[BIT20_IDX])
        else $error("line twenty not masked");
    chk_rx_pulse: assert property (RX_VALID |=> !RX_VALID)
        else $error("receive pulse too long");
endmodule // sbrap_asserts

bind sbrap_top sbrap_asserts u_chk (.*);
`default_nettype wire

// *** sbrap_agent.sv ***
// behavioural model of another bus agent: sends requests, latches what it sees
// assumes pull-ups on every wire, resolved outside, and a free-running bus clock
`timescale 1ns/10ps
`default_nettype none
module sbrap_agent
    import sbrap_pkg::*;
(
    input wire logic bus_clk,
    input wire logic [ADDR_W-1:0] lines_n,
    input wire logic [1:0] stb_n,
    output logic [ADDR_W-1:0] l_n,
    output logic [1:0] s_n,
    output logic [1:0] p_n,
    output logic v_n,
    output logic oe
);
    logic [ADDR_W-1:0] got_addr = '0; // subphase one word, logical
    logic [ADDR_W-1:0] got_kind = '0; // subphase two word, logical
    initial begin
        l_n = '1;
        s_n = 2'h3;
        p_n = 2'h3;
        v_n = 1'b1;
        oe = 1'b0;
    end
    // each strobe latches its own group; never the bus clock
    always @(negedge stb_n[0]) got_addr[GRP0_MSB:0] = ~lines_n[GRP0_MSB:0];
    always @(posedge stb_n[0]) got_kind[GRP0_MSB:0] = ~lines_n[GRP0_MSB:0];
    always @(negedge stb_n[1]) got_addr[32:GRP0_MSB+1] = ~lines_n[32:GRP0_MSB+1];
    always @(posedge stb_n[1]) got_kind[32:GRP0_MSB+1] = ~lines_n[32:GRP0_MSB+1];
    // pins plus parity; bad flips the low parity pin only
    task automatic drive(input logic [ADDR_W-1:0] pins, input logic bad);
        l_n = pins;
        p_n = {~^(~pins[32:PAR0_LSB]), (~^(~pins[PAR0_LSB-1:0])) ^ bad};
    endtask
    // static levels held across bus reset release
    task automatic strap(input logic [ADDR_W-1:0] v, input logic on);
        l_n = ~v;
        oe = on;
    endtask
    // data settles 40 ns ahead of each strobe edge
    task automatic send(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] k, input logic bad);
        @(posedge bus_clk);
        #1;
        drive(~a, bad);
        v_n = 1'b0;
        oe = 1'b1;
        #40 s_n = 2'h0;
        @(posedge bus_clk);
        #1;
        drive(~k, 1'b0);
        v_n = 1'b1;
        #40 s_n = 2'h3;
        @(posedge bus_clk);
        #1 oe = 1'b0;
    endtask
endmodule // sbrap_agent
`default_nettype wire

// *** sbrap_bench.sv ***
// self-checking bench of the request address phase
// assumes sbrap_top, the agent model and a pull-up on every bus wire
`timescale 1ns/10ps
`default_nettype none
module sbrap_bench;
    import sbrap_pkg::*;
    // request, type, expected lookup, mask pin, real mode
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] kind;
        logic [ADDR_W-1:0] look;
        logic mask_n;
        logic real_md;
    } sbrap_row_t;
    sbrap_row_t rows [4] = '{
        {33'h0_2346_5678, 33'h0_0000_0015, 33'h0_2346_5678, 1'b1, 1'b1},
        {33'h0_2346_5678, 33'h1_0000_000A, 33'h0_2344_5678, 1'b0, 1'b1},
        {33'h1_FFFF_FFFF, 33'h0_0000_0000, 33'h1_FFFF_FFFF, 1'b0, 1'b0},
        {33'h1_FFFF_FFFF, 33'h1_5555_5555, 33'h1_FFFD_FFFF, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic bclk = 1'b0;
    logic brst_n = 1'b0;
    logic mask_n = 1'b1;
    logic real_md = 1'b1;
    logic req_v = 1'b0;
    sbrap_req_t req_w = '0;
    logic rdy, l_oe, s_oe, p_oe, v_oe, v_do, rxv, a_oe, v_ao, vld;
    logic [ADDR_W-1:0] look, l_do, cfg, l_ao, lines;
    logic [1:0] s_do, p_do, s_ao, p_ao, stb, par;
    sbrap_rx_t rxw;
    int failures = 0;
    int comparisons = 0;
    // pull-up wires: any low driver wins, released wires float high
    assign lines = (l_oe ? l_do : '1) & (a_oe ? l_ao : '1);
    assign stb = (s_oe ? s_do : 2'h3) & (a_oe ? s_ao : 2'h3);
    assign par = (p_oe ? p_do : 2'h3) & (a_oe ? p_ao : 2'h3);
    assign vld = (v_oe ? v_do : 1'b1) & (a_oe ? v_ao : 1'b1);
    always #5 clk = ~clk;
    // bus clock offset 3 ns so its edges never meet the system clock
    initial begin
        #3;
        forever #80 bclk = ~bclk;
    end
    sbrap_top dut (.CLOCK(clk), .RSTN(rstn), .BUS_CLK(bclk), .BUS_RESET_N(brst_n),
        .BIT20_MASK_IN_N(mask_n), .REAL_MODE(real_md), .REQ_VALID(req_v), .REQ_WORD(req_w),
        .REQ_READY(rdy), .LOOKUP_ADDR(look), .ADDR_LINES_N_IN(lines), .ADDR_LINES_N_OUT(l_do),
        .ADDR_LINES_OE(l_oe), .ADDR_SRC_STROBES_N_IN(stb), .ADDR_SRC_STROBES_N_OUT(s_do),
        .ADDR_SRC_STROBES_OE(s_oe), .ADDR_PARITY_PAIR_N_IN(par), .ADDR_PARITY_PAIR_N_OUT(p_do),
        .ADDR_PARITY_PAIR_OE(p_oe), .ADDR_VALID_STROBE_N_IN(vld),
        .ADDR_VALID_STROBE_N_OUT(v_do), .ADDR_VALID_STROBE_OE(v_oe), .RX_VALID(rxv),
        .RX_WORD(rxw), .CFG_WORD(cfg));
    sbrap_agent pt (.bus_clk(bclk), .lines_n(lines), .stb_n(stb), .l_n(l_ao), .s_n(s_ao),
        .p_n(p_ao), .v_n(v_ao), .oe(a_oe));
    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [66:0] got, input logic [66:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // 0 ready, 1 received, 2 driving, 3 released; bounded
    task automatic wait_for(input int sel);
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            #1;
            if ((sel == 0 && rdy === 1'b1) || (sel == 1 && rxv === 1'b1) ||
                (sel == 2 && l_oe === 1'b1) || (sel == 3 && l_oe === 1'b0)) break;
        end
        if (n == 3000) begin
            failures++;
            print_verdict();
        end
    endtask
    // one core request through to the end of its bus transfer
    task automatic request(input sbrap_row_t r);
        @(negedge clk);
        mask_n = r.mask_n;
        real_md = r.real_md;
        repeat (6) @(negedge clk);
        req_w = {r.addr, r.kind};
        req_v = 1'b1;
        wait_for(0);
        chk(look, r.look);
        @(negedge clk);
        req_v = 1'b0;
        wait_for(2);
        wait_for(3);
        chk(pt.got_addr, r.look);
        chk(pt.got_kind, r.kind);
    endtask
    // another agent's request, optionally with bad parity
    task automatic recv(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] k, input logic bad);
        fork
            pt.send(a, k, bad);
            wait_for(1);
        join
        chk(rxw, {a, k, bad});
    endtask
    initial begin
        #12;
        chk({l_oe, rxv, rdy, cfg}, '0);
        pt.strap(33'h0_5A5A_5A5A, 1'b1);
        @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        brst_n = 1'b1;
        repeat (8) @(negedge clk);
        chk(cfg, 33'h0_5A5A_5A5A);
        pt.strap('0, 1'b0);
        foreach (rows[i]) request(rows[i]);
        recv(33'h1_0F0F_1234, 33'h0_0000_0007, 1'b0);
        recv(33'h0_8421_0FED, 33'h1_0000_0003, 1'b1);
        // held request refused while a transfer is pending, then reset mid-transfer
        @(negedge clk);
        req_v = 1'b1;
        wait_for(0);
        @(posedge clk);
        repeat (3) @(negedge clk) chk(rdy, 1'b0);
        wait_for(2);
        chk(rdy, 1'b0);
        @(negedge clk);
        rstn = 1'b0;
        req_v = 1'b0;
        #1;
        chk({l_oe, s_oe, p_oe, v_oe, rxv}, '0);
        chk(&{l_do, s_do, p_do, v_do}, 1'b1);
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        request(rows[3]);
        print_verdict();
    end
endmodule // sbrap_bench
`default_nettype wire
